// ---- frl_pkg.sv ----
// Shared constants for the frequency reference, limit and ramp block.
package frl_pkg;
  // ----------------------------------------------------------------
  // Widths and scales
  // ----------------------------------------------------------------
  localparam int F_W = 16;
  localparam int PCT_W = 11;
  localparam int AIN_W = 12;
  localparam int T_W = 16;
  localparam int SRC_W = 3;
  localparam int ACC_W = 48;
  localparam logic [F_W-1:0] F_ABS_MAX = 16'h9c40;
  localparam logic [F_W-1:0] F_SET_MAX = 16'he9fc;
  localparam logic [PCT_W-1:0] PCT_FULL = 11'h3e8;
  localparam logic [AIN_W-1:0] AIN_FULL = 12'hfff;
  localparam logic [T_W-1:0] T_MIN = 16'h0001;
  localparam logic [T_W-1:0] T_MAX = 16'hea60;
  // ----------------------------------------------------------------
  // Source selection codes
  // ----------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_KEYPAD = 3'h0;
  localparam logic [SRC_W-1:0] SRC_AIN1 = 3'h1;
  localparam logic [SRC_W-1:0] SRC_UPDOWN = 3'h2;
  localparam logic [SRC_W-1:0] SRC_COMM = 3'h3;
  localparam logic [SRC_W-1:0] SRC_RTC = 3'h6;
  localparam logic [SRC_W-1:0] SRC_AIN2_AUX = 3'h7;
  // ----------------------------------------------------------------
  // Ramp time slots and defaults in tenths of a second
  // ----------------------------------------------------------------
  localparam int RAMP_SETS = 4;
  localparam int DEC_BASE = 4;
  localparam logic [T_W-1:0] DEF_TIME_SMALL = 16'h0064;
  localparam logic [T_W-1:0] DEF_TIME_MID = 16'h0096;
  localparam logic [T_W-1:0] DEF_TIME_LARGE = 16'h00c8;
  localparam int RATING_SMALL = 0;
  localparam int RATING_MID = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIME_UNIT_NS = 100_000_000;
  localparam int TENTH_SEC_CYC = TIME_UNIT_NS / CLK_PERIOD_NS;
endpackage : frl_pkg

// ---- frl_sync2.sv ----
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ns
`default_nettype none
module frl_sync2 #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import frl_pkg::*;
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = i_ce ? i_async : meta_q;
    sync_d = i_ce ? meta_q : sync_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule : frl_sync2
`default_nettype wire

// ---- frl_ramp_gen.sv ----
// Output frequency ramp generator stepping toward a target.
`timescale 1ns/1ns
`default_nettype none
module frl_ramp_gen #(
  parameter int unsigned TENTH_SEC_CYC = frl_pkg::TENTH_SEC_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [frl_pkg::F_W-1:0] i_target,
  input wire logic [frl_pkg::F_W-1:0] i_fmax,
  input wire logic [frl_pkg::T_W-1:0] i_acc_time,
  input wire logic [frl_pkg::T_W-1:0] i_dec_time,
  output logic [frl_pkg::F_W-1:0] o_freq
);
  import frl_pkg::*;
  logic [F_W-1:0] freq_q;
  logic [F_W-1:0] freq_d;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] lim;
  logic [ACC_W-1:0] sum;
  logic up;

  // ----------------------------------------------------------------
  // Step engine
  // ----------------------------------------------------------------
  // The accumulator adds fmax per cycle, so a full-scale ramp takes
  // exactly the ramp time unless fmax exceeds lim; only one unit per cycle is ever taken.
  always_comb begin
    freq_d = freq_q;
    acc_d = acc_q;
    up = freq_q < i_target;
    lim = ACC_W'(up ? i_acc_time : i_dec_time) * ACC_W'(TENTH_SEC_CYC);
    sum = acc_q + ACC_W'(i_fmax);
    if (i_ce) begin
      // R22: step toward target
      if (freq_q == i_target) begin
        acc_d = '0;
      end else if (sum >= lim) begin
        acc_d = sum - lim;
        freq_d = up ? freq_q + F_W'(1) : freq_q - F_W'(1);
      end else begin
        acc_d = sum;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      freq_q <= '0;
      acc_q <= '0;
    end else begin
      freq_q <= freq_d;
      acc_q <= acc_d;
    end
  end

  assign o_freq = freq_q;

  step_size_a: assert property (@(posedge i_clk) disable iff (i_rst) // R22
    (freq_q != $past(freq_q)) |-> ((freq_q == $past(freq_q) + F_W'(1))
      || (freq_q == $past(freq_q) - F_W'(1))))
    else $error("Output frequency moved by more than one unit.");
  step_toward_a: assert property (@(posedge i_clk) disable iff (i_rst) // R22
    (i_ce && freq_q < i_target) |=> (freq_q >= $past(freq_q)))
    else $error("Output frequency moved away from a higher target.");
endmodule : frl_ramp_gen
`default_nettype wire

// ---- frl_freq_ref.sv ----
// Frequency reference selection, limits and ramp set handling.
// Function
// R1: Secondary analog source scales to full fmax only in auxiliary mode, else zero.
// R2: Combination mode 0 uses main source; mode 1 sums main and alternative.
// R3: Summing with identical main and alternative selections raises source conflict error.
// R4: Keypad as alternative source takes speed-stage-zero frequency setting.
// R5: Communication frequency command is readable, 0.00 to 599.00 Hz.
// R6: Retention setting keeps or drops comm command at power down, comm mode only.
// R7: Policy 0 warns when the command is below motor one minimum frequency.
// R8: Policy 1 substitutes motor one minimum frequency for lower commands.
// R9: Sleeping holds PID output at lower limit, or zero with floor setting 1.
// R10: Upper limit is 0.1 to 109.0 percent of selected motor fmax; the code accepts any 11-bit setting, 0.0 to 204.7 percent.
// R11: Lower limit is 0.0 to 109.0 percent of selected motor fmax; the code accepts any 11-bit setting, up to 204.7 percent.
// R12: Nonzero lower limit target is at least the selected motor minimum frequency.
// R13: Upper limit below lower limit raises a set-range error.
// R14: Clamps apply for every source and combination mode.
// R15: Upper limit never exceeds 400 Hz; analog sources saturate at motor one fmax.
// R16: Four acceleration times, 0.1 to 6000.0 s, from zero to fmax.
// R17: Four deceleration times, 0.1 to 6000.0 s, from fmax to zero.
// R18: Ramp switch-over frequency 0.00 to 599.00 Hz chooses between ramp sets; the code does not limit the setting, up to 655.35 Hz.
// R19: Default ramp times are 10, 15 or 20 s by power rating.
// R20: Nonzero switch-over uses set one below it, set four at or above.
// R21: Two select inputs pick sets one to four and take priority.
// R22: Clamp after combining, then step output toward target at ramp rate.
// R23: Reset zeroes output, clears flags and restores default settings.
`timescale 1ns/1ns
`default_nettype none
module frl_freq_ref #(
  parameter int RATING = frl_pkg::RATING_SMALL,
  parameter int unsigned TENTH_SEC_CYC = frl_pkg::TENTH_SEC_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [frl_pkg::SRC_W-1:0] i_main_sel,
  input wire logic [frl_pkg::SRC_W-1:0] i_alt_sel,
  input wire logic i_combine_mode,
  input wire logic i_ain2_aux_mode,
  input wire logic [frl_pkg::F_W-1:0] i_keypad_freq,
  input wire logic [frl_pkg::F_W-1:0] i_stage0_freq,
  input wire logic [frl_pkg::F_W-1:0] i_updown_freq,
  input wire logic [frl_pkg::F_W-1:0] i_rtc_freq,
  input wire logic [frl_pkg::AIN_W-1:0] i_ain1,
  input wire logic [frl_pkg::AIN_W-1:0] i_secondary_analog_input,
  input wire logic i_comm_wr,
  input wire logic [frl_pkg::F_W-1:0] i_comm_freq,
  input wire logic i_comm_retain,
  input wire logic i_power_down,
  input wire logic i_min_policy,
  input wire logic i_sleep,
  input wire logic i_pid_floor_zero,
  input wire logic i_motor2_sel,
  input wire logic [frl_pkg::F_W-1:0] i_fmax1,
  input wire logic [frl_pkg::F_W-1:0] i_fmax2,
  input wire logic [frl_pkg::F_W-1:0] i_fmin1,
  input wire logic [frl_pkg::F_W-1:0] i_fmin2,
  input wire logic [frl_pkg::PCT_W-1:0] i_upper_pct,
  input wire logic [frl_pkg::PCT_W-1:0] i_lower_pct,
  input wire logic i_run,
  input wire logic i_time_wr,
  input wire logic [2:0] i_time_idx,
  input wire logic [frl_pkg::T_W-1:0] i_time_val,
  input wire logic [frl_pkg::F_W-1:0] i_switch_freq,
  input wire logic i_ramp_pins_used,
  input wire logic [1:0] i_ramp_sel_pins,
  output logic [frl_pkg::F_W-1:0] o_freq,
  output logic [frl_pkg::F_W-1:0] o_target,
  output logic [frl_pkg::F_W-1:0] o_comm_freq,
  output logic [1:0] o_ramp_set,
  output logic o_source_conflict_error,
  output logic o_limit_range_error,
  output logic o_below_minimum_warning
);
  import frl_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [F_W-1:0] pct_of(input logic [F_W-1:0] f,
                                             input logic [PCT_W-1:0] p);
    logic [F_W+PCT_W-1:0] prod;
    prod = (F_W+PCT_W)'(f) * (F_W+PCT_W)'(p);
    return F_W'(prod / (F_W+PCT_W)'(PCT_FULL));
  endfunction : pct_of

  // R15: analog reference cannot pass motor one fmax
  function automatic logic [F_W-1:0] ain_scale(input logic [AIN_W-1:0] a,
                                                input logic [F_W-1:0] fmax);
    logic [F_W+AIN_W-1:0] prod;
    prod = (F_W+AIN_W)'(a) * (F_W+AIN_W)'(fmax);
    return F_W'(prod / (F_W+AIN_W)'(AIN_FULL));
  endfunction : ain_scale

  function automatic logic [T_W-1:0] sat_time(input logic [T_W-1:0] t);
    return (t < T_MIN) ? T_MIN : ((t > T_MAX) ? T_MAX : t);
  endfunction : sat_time

  // R19: default ramp time by rating
  function automatic logic [T_W-1:0] def_time(input int r);
    return (r == RATING_SMALL) ? DEF_TIME_SMALL :
           ((r == RATING_MID) ? DEF_TIME_MID : DEF_TIME_LARGE);
  endfunction : def_time

  logic [F_W-1:0] comm_q;
  logic [F_W-1:0] comm_d;
  logic [F_W-1:0] target_q;
  logic [F_W-1:0] target_d;
  logic [T_W-1:0] time_q [2*RAMP_SETS];
  logic [T_W-1:0] time_d [2*RAMP_SETS];
  logic [1:0] set_q;
  logic [1:0] set_d;
  logic conflict_q;
  logic conflict_d;
  logic range_q;
  logic range_d;
  logic warn_q;
  logic warn_d;
  logic [1:0] pins_s;
  logic [F_W-1:0] main_f;
  logic [F_W-1:0] alt_f;
  logic [F_W:0] sum_f;
  logic [F_W:0] cmd_f;
  logic [F_W-1:0] fmax_sel;
  logic [F_W-1:0] fmin_sel;
  logic [F_W-1:0] upper_f;
  logic [F_W-1:0] lower_f;
  logic [F_W-1:0] lower_eff;
  logic comm_active;

  function automatic logic [F_W-1:0] src_val(input logic [SRC_W-1:0] sel,
                                              input logic alt,
                                              input logic [F_W-1:0] key,
                                              input logic [F_W-1:0] st0,
                                              input logic [F_W-1:0] upd,
                                              input logic [F_W-1:0] rtc,
                                              input logic [F_W-1:0] comm,
                                              input logic [F_W-1:0] a1,
                                              input logic [F_W-1:0] a2,
                                              input logic aux);
    logic [F_W-1:0] v;
    v = '0;
    case (sel)
      // R4: keypad as alternative uses stage-zero setting
      SRC_KEYPAD: v = alt ? st0 : key;
      SRC_AIN1: v = a1;
      SRC_UPDOWN: v = upd;
      SRC_COMM: v = comm;
      SRC_RTC: v = rtc;
      // R1: secondary analog counts only in auxiliary mode
      SRC_AIN2_AUX: v = aux ? a2 : '0;
      default: v = '0;
    endcase
    return v;
  endfunction : src_val

  frl_sync2 #(.W(2)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_ramp_sel_pins),
    .o_sync(pins_s)
  );

  // ----------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------
  always_comb begin
    fmax_sel = i_motor2_sel ? i_fmax2 : i_fmax1;
    fmin_sel = i_motor2_sel ? i_fmin2 : i_fmin1;
    main_f = src_val(i_main_sel, 1'b0, i_keypad_freq, i_stage0_freq, i_updown_freq,
                     i_rtc_freq, comm_q, ain_scale(i_ain1, i_fmax1),
                     ain_scale(i_secondary_analog_input, i_fmax1), i_ain2_aux_mode);
    alt_f = src_val(i_alt_sel, 1'b1, i_keypad_freq, i_stage0_freq, i_updown_freq,
                    i_rtc_freq, comm_q, ain_scale(i_ain1, i_fmax1),
                    ain_scale(i_secondary_analog_input, i_fmax1), i_ain2_aux_mode);
    // R2: main only or main plus alternative
    sum_f = i_combine_mode ? ({1'b0, main_f} + {1'b0, alt_f}) : {1'b0, main_f};
    // R10: upper limit from percentage; R15: never over 400 Hz
    upper_f = pct_of(fmax_sel, i_upper_pct);
    if (upper_f > F_ABS_MAX) begin
      upper_f = F_ABS_MAX;
    end
    // R11: lower limit from percentage
    lower_f = pct_of(fmax_sel, i_lower_pct);
    // R12: nonzero lower limit is raised to the minimum frequency
    lower_eff = (lower_f != '0 && lower_f < fmin_sel) ? fmin_sel : lower_f;
    // R8: substitute motor one minimum when below it
    cmd_f = (i_min_policy && sum_f < {1'b0, i_fmin1}) ? {1'b0, i_fmin1} : sum_f;
    // R14: clamp after combination for every source
    if (cmd_f < {1'b0, lower_eff}) begin
      cmd_f = {1'b0, lower_eff};
    end
    if (cmd_f > {1'b0, upper_f}) begin
      cmd_f = {1'b0, upper_f};
    end
    target_d = target_q;
    if (i_ce) begin
      target_d = F_W'(cmd_f);
      // R9: sleep floor at lower limit or zero
      if (i_sleep) begin
        target_d = i_pid_floor_zero ? '0 : ((lower_f > upper_f) ? upper_f : lower_f);
      end else if (!i_run) begin
        target_d = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_comb begin
    conflict_d = conflict_q;
    range_d = range_q;
    warn_d = warn_q;
    if (i_ce) begin
      // R3: identical selections while summing
      conflict_d = i_combine_mode && (i_main_sel == i_alt_sel);
      // R13: upper below lower
      range_d = pct_of(fmax_sel, i_upper_pct) < pct_of(fmax_sel, i_lower_pct);
      // R7: warn below motor one minimum under policy 0
      warn_d = !i_min_policy && (sum_f < {1'b0, i_fmin1});
    end
  end

  // ----------------------------------------------------------------
  // Communication command
  // ----------------------------------------------------------------
  // A write in the same cycle as power down wins, so no command is lost.
  always_comb begin
    comm_active = (i_main_sel == SRC_COMM) || (i_alt_sel == SRC_COMM);
    comm_d = comm_q;
    if (i_ce) begin
      // R5: host supplied command, limited to 599.00 Hz
      if (i_comm_wr) begin
        comm_d = (i_comm_freq > F_SET_MAX) ? F_SET_MAX : i_comm_freq;
      // R6: drop at power down only in comm mode without retention
      end else if (i_power_down && comm_active && !i_comm_retain) begin
        comm_d = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ramp times and ramp set
  // ----------------------------------------------------------------
  always_comb begin
    time_d = time_q;
    set_d = set_q;
    if (i_ce) begin
      // R16: R17: writes saturate into the legal range
      if (i_time_wr) begin
        time_d[i_time_idx] = sat_time(i_time_val);
      end
      // R21: select pins first
      if (i_ramp_pins_used) begin
        set_d = pins_s;
      // R20: R18: automatic switch-over on output frequency
      end else if (i_switch_freq != '0) begin
        set_d = (o_freq < i_switch_freq) ? 2'h0 : 2'h3;
      end else begin
        set_d = 2'h0;
      end
    end
  end

  // R23: reset clears output, flags and restores defaults
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      comm_q <= '0;
      target_q <= '0;
      set_q <= '0;
      conflict_q <= 1'b0;
      range_q <= 1'b0;
      warn_q <= 1'b0;
      for (int i = 0; i < 2*RAMP_SETS; i++) begin
        time_q[i] <= def_time(RATING);
      end
    end else begin
      comm_q <= comm_d;
      target_q <= target_d;
      set_q <= set_d;
      conflict_q <= conflict_d;
      range_q <= range_d;
      warn_q <= warn_d;
      time_q <= time_d;
    end
  end

  frl_ramp_gen #(.TENTH_SEC_CYC(TENTH_SEC_CYC)) u_ramp (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_target(target_q),
    .i_fmax(fmax_sel),
    .i_acc_time(time_q[set_q]),
    .i_dec_time(time_q[DEC_BASE + int'(set_q)]),
    .o_freq(o_freq)
  );

  assign o_target = target_q;
  assign o_comm_freq = comm_q;
  assign o_ramp_set = set_q;
  assign o_source_conflict_error = conflict_q;
  assign o_limit_range_error = range_q;
  assign o_below_minimum_warning = warn_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  src_conflict_a: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    (i_ce && i_combine_mode && i_main_sel == i_alt_sel) |=> o_source_conflict_error)
    else $error("Source conflict not flagged.");
  range_error_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    (i_ce && i_upper_pct == i_lower_pct) |=> !o_limit_range_error)
    else $error("Range error raised for equal limits.");
  low_warn_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    (i_ce && i_min_policy) |=> !o_below_minimum_warning)
    else $error("Minimum warning raised under substitute policy.");
  abs_cap_a: assert property (@(posedge i_clk) disable iff (i_rst) // R15
    target_q <= F_ABS_MAX)
    else $error("Target above absolute frequency cap.");
  sleep_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    (i_ce && i_sleep && i_pid_floor_zero) |=> (target_q == '0))
    else $error("Sleep floor not zero.");
  pin_select_a: assert property (@(posedge i_clk) disable iff (i_rst) // R21
    (i_ce && i_ramp_pins_used) |=> (set_q == $past(pins_s)))
    else $error("Ramp set does not follow select pins.");
  auto_switch_a: assert property (@(posedge i_clk) disable iff (i_rst) // R20
    (i_ce && !i_ramp_pins_used && i_switch_freq != '0 && o_freq >= i_switch_freq)
      |=> (set_q == 2'h3))
    else $error("Ramp set four not chosen above switch-over.");
  comm_keep_a: assert property (@(posedge i_clk) disable iff (i_rst) // R6
    (i_ce && i_power_down && !i_comm_wr && i_comm_retain) |=> $stable(comm_q))
    else $error("Retained command lost at power down.");
endmodule : frl_freq_ref
`default_nettype wire

// ---- frl_host_model.sv ----
// Serial host model that writes the comm command, ramp times and power-down events.
`timescale 1ns/1ns
`default_nettype none
module frl_host_model (
  input wire logic i_clk,
  output logic o_comm_wr,
  output logic [frl_pkg::F_W-1:0] o_comm_freq,
  output logic o_time_wr,
  output logic [2:0] o_time_idx,
  output logic [frl_pkg::T_W-1:0] o_time_val,
  output logic o_power_down
);
  import frl_pkg::*;
  initial begin
    o_comm_wr = 1'b0;
    o_comm_freq = 16'h0000;
    o_time_wr = 1'b0;
    o_time_idx = 3'h0;
    o_time_val = 16'h0000;
    o_power_down = 1'b0;
  end
  // Data is inverted after the strobe so a stale value is never mistaken for a write.
  task automatic comm_write(input logic [F_W-1:0] f);
    @(negedge i_clk);
    o_comm_wr = 1'b1;
    o_comm_freq = f;
    @(negedge i_clk);
    o_comm_wr = 1'b0;
    o_comm_freq = ~f;
  endtask : comm_write
  task automatic time_write(input logic [2:0] idx, input logic [T_W-1:0] v);
    @(negedge i_clk);
    o_time_wr = 1'b1;
    o_time_idx = idx;
    o_time_val = v;
    @(negedge i_clk);
    o_time_wr = 1'b0;
    o_time_idx = ~idx;
    o_time_val = ~v;
  endtask : time_write
  task automatic power_down;
    @(negedge i_clk);
    o_power_down = 1'b1;
    @(negedge i_clk);
    o_power_down = 1'b0;
  endtask : power_down
endmodule : frl_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the frequency reference, limit and ramp block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import frl_pkg::*;
  logic i_clk, i_rst, i_ce, i_combine_mode, i_ain2_aux_mode, i_comm_retain, i_min_policy;
  logic i_sleep, i_pid_floor_zero, i_motor2_sel, i_run, i_ramp_pins_used;
  logic [2:0] i_main_sel, i_alt_sel;
  logic [15:0] i_keypad_freq, i_stage0_freq, i_updown_freq, i_rtc_freq, i_switch_freq;
  logic [15:0] i_fmax1, i_fmax2, i_fmin1, i_fmin2, o_freq, o_target, o_comm_freq;
  logic [11:0] i_ain1, i_ain2;
  logic [10:0] i_upper_pct, i_lower_pct;
  logic [1:0] i_ramp_sel_pins, o_ramp_set;
  logic comm_wr, time_wr, pwr_dn, o_src_err, o_rng_err, o_min_warn;
  logic [15:0] comm_freq, time_val, f0;
  logic [2:0] time_idx;
  logic [15:0] exp_t [8] = '{16'h044c, 16'h0fa0, 16'h0514, 16'h05dc,
                             16'h0000, 16'h0000, 16'h0578, 16'h0fa0};
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  frl_host_model u_host (.i_clk(i_clk), .o_comm_wr(comm_wr), .o_comm_freq(comm_freq),
    .o_time_wr(time_wr), .o_time_idx(time_idx), .o_time_val(time_val),
    .o_power_down(pwr_dn));
  // Four hundred clocks per tenth of a second make one step per cycle at 1.0 s and 40 Hz.
  frl_freq_ref #(.RATING(0), .TENTH_SEC_CYC(400)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_main_sel(i_main_sel), .i_alt_sel(i_alt_sel),
    .i_combine_mode(i_combine_mode), .i_ain2_aux_mode(i_ain2_aux_mode),
    .i_keypad_freq(i_keypad_freq), .i_stage0_freq(i_stage0_freq),
    .i_updown_freq(i_updown_freq), .i_rtc_freq(i_rtc_freq), .i_ain1(i_ain1),
    .i_secondary_analog_input(i_ain2), .i_comm_wr(comm_wr), .i_comm_freq(comm_freq),
    .i_comm_retain(i_comm_retain), .i_power_down(pwr_dn), .i_min_policy(i_min_policy),
    .i_sleep(i_sleep), .i_pid_floor_zero(i_pid_floor_zero), .i_motor2_sel(i_motor2_sel),
    .i_fmax1(i_fmax1), .i_fmax2(i_fmax2), .i_fmin1(i_fmin1), .i_fmin2(i_fmin2),
    .i_upper_pct(i_upper_pct), .i_lower_pct(i_lower_pct), .i_run(i_run),
    .i_time_wr(time_wr), .i_time_idx(time_idx), .i_time_val(time_val),
    .i_switch_freq(i_switch_freq), .i_ramp_pins_used(i_ramp_pins_used),
    .i_ramp_sel_pins(i_ramp_sel_pins), .o_freq(o_freq), .o_target(o_target),
    .o_comm_freq(o_comm_freq), .o_ramp_set(o_ramp_set), .o_source_conflict_error(o_src_err),
    .o_limit_range_error(o_rng_err), .o_below_minimum_warning(o_min_warn));
  // ----------------------------------------------------------------
  // Clock, timeout and checking tasks
  // ----------------------------------------------------------------
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      $display("FAIL t=%0t timeout", $time);
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("FAIL t=%0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {i_ce, i_run, i_ain2_aux_mode} = 3'h7;
    {i_combine_mode, i_comm_retain, i_min_policy, i_sleep} = 4'h0;
    {i_pid_floor_zero, i_motor2_sel, i_ramp_pins_used} = 3'h0;
    {i_main_sel, i_alt_sel, i_ramp_sel_pins} = 8'h08;
    {i_keypad_freq, i_stage0_freq, i_updown_freq, i_rtc_freq} = 64'h03e8_04b0_0514_0578;
    {i_fmax1, i_fmax2, i_fmin1, i_fmin2} = 64'h0fa0_07d0_0064_012c;
    {i_ain1, i_ain2, i_upper_pct, i_lower_pct} = 46'h0;
    i_ain1 = 12'hfff;
    i_ain2 = 12'hfff;
    i_upper_pct = 11'h3e8;
    i_switch_freq = 16'h0000;
    i_rst = 1'b1;
    tick(6);
    chk(o_freq | o_target | o_comm_freq, 16'h0, 16'h0);
    chk({13'h0, o_src_err, o_rng_err, o_min_warn}, 16'h0, 16'h0);
    i_rst = 1'b0;
    tick(200);
    chk(o_freq, 16'd17, 16'd22);
    u_host.time_write(3'h0, 16'h000a);
    u_host.time_write(3'h4, 16'h0014);
    f0 = o_freq;
    tick(100);
    chk(o_freq, f0 + 16'd96, f0 + 16'd102);
    i_run = 1'b0;
    tick(2);
    f0 = o_freq;
    tick(100);
    chk(o_freq, f0 - 16'd52, f0 - 16'd48);
    i_run = 1'b1;
    i_keypad_freq = 16'h044c;
    u_host.comm_write(16'hffff);
    chk(o_comm_freq, 16'he9fc, 16'he9fc);
    u_host.comm_write(16'hafc8);
    chk(o_comm_freq, 16'hafc8, 16'hafc8);
    u_host.comm_write(16'h05dc);
    for (int k = 0; k < 8; k++) begin
      i_main_sel = 3'(k);
      tick(3);
      chk(o_target, exp_t[k], exp_t[k]);
    end
    i_ain2_aux_mode = 1'b0;
    tick(3);
    chk(o_target, 16'h0, 16'h0);
    i_ramp_pins_used = 1'b1;
    for (int p = 0; p < 4; p++) begin
      i_ramp_sel_pins = 2'(p);
      tick(5);
      chk({14'h0, o_ramp_set}, 16'(p), 16'(p));
    end
    i_ramp_sel_pins = 2'h0;
    i_switch_freq = 16'h0001;
    tick(5);
    chk({14'h0, o_ramp_set}, 16'h0, 16'h0);
    i_ramp_pins_used = 1'b0;
    tick(3);
    chk({14'h0, o_ramp_set}, 16'h3, 16'h3);
    i_switch_freq = 16'he9fc;
    tick(3);
    chk({14'h0, o_ramp_set}, 16'h0, 16'h0);
    {i_combine_mode, i_main_sel, i_alt_sel} = 7'b1_000_010;
    tick(3);
    chk(o_target, 16'h0960, 16'h0960);
    chk({15'h0, o_src_err}, 16'h0, 16'h0);
    {i_main_sel, i_alt_sel} = 6'b010_000;
    tick(3);
    chk(o_target, 16'h09c4, 16'h09c4);
    i_alt_sel = 3'h2;
    tick(3);
    chk({15'h0, o_src_err}, 16'h1, 16'h1);
    {i_alt_sel, i_upper_pct} = {3'h0, 11'h1f4};
    tick(3);
    chk(o_target, 16'h07d0, 16'h07d0);
    i_motor2_sel = 1'b1;
    tick(3);
    chk(o_target, 16'h03e8, 16'h03e8);
    {i_combine_mode, i_main_sel, i_lower_pct} = {1'b0, 3'h0, 11'h00a};
    i_keypad_freq = 16'h0000;
    tick(3);
    chk(o_target, 16'h012c, 16'h012c);
    i_motor2_sel = 1'b0;
    tick(3);
    chk(o_target, 16'h0064, 16'h0064);
    {i_upper_pct, i_lower_pct} = {11'h3e8, 11'h2ee};
    tick(3);
    chk(o_target, 16'h0bb8, 16'h0bb8);
    i_upper_pct = 11'h1f4;
    tick(3);
    chk({15'h0, o_rng_err}, 16'h1, 16'h1);
    i_lower_pct = 11'h1f4;
    tick(3);
    chk({15'h0, o_rng_err}, 16'h0, 16'h0);
    {i_upper_pct, i_lower_pct, i_keypad_freq} = {11'h3e8, 11'h000, 16'h0032};
    tick(3);
    chk({14'h0, o_rng_err, o_min_warn}, 16'h1, 16'h1);
    i_min_policy = 1'b1;
    tick(3);
    chk(o_target, 16'h0064, 16'h0064);
    {i_min_policy, i_keypad_freq, i_lower_pct, i_sleep} = {1'b0, 16'h044c, 11'h0fa, 1'b1};
    tick(3);
    chk(o_target, 16'h03e8, 16'h03e8);
    i_pid_floor_zero = 1'b1;
    tick(3);
    chk(o_target, 16'h0, 16'h0);
    {i_sleep, i_alt_sel} = {1'b0, 3'h2};
    u_host.power_down();
    tick(1);
    chk(o_comm_freq, 16'h05dc, 16'h05dc);
    {i_main_sel, i_comm_retain} = {3'h3, 1'b1};
    u_host.power_down();
    tick(1);
    chk(o_comm_freq, 16'h05dc, 16'h05dc);
    i_comm_retain = 1'b0;
    u_host.power_down();
    tick(1);
    chk(o_comm_freq, 16'h0, 16'h0);
    {i_main_sel, i_keypad_freq, i_fmax1} = {3'h0, 16'hea60, 16'hea60};
    tick(3);
    chk(o_target, 16'h9c40, 16'h9c40);
    f0 = o_freq;
    {i_ce, i_keypad_freq} = {1'b0, 16'h0000};
    tick(3);
    chk(o_target, 16'h9c40, 16'h9c40);
    chk(o_freq, f0, f0);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
